// >>> oss_pkg.sv
// constants shared by the octal switch serial control block
package oss_pkg;

  localparam int          OSS_CH         = 8;
  localparam logic [2:0]  OSS_MSB        = 3'h7;
  localparam int          OSS_CNT_W      = 4;
  localparam logic [3:0]  OSS_FULL       = 4'h8;
  localparam logic [3:0]  OSS_CNT_RST    = 4'h0;
  localparam logic [7:0]  OSS_ALL_OFF    = 8'hFF;
  localparam logic [7:0]  OSS_ALL_ON     = 8'h00;
  localparam logic [7:0]  OSS_WORD_RST   = 8'h00;

  // synchronised pin vector layout
  localparam int          OSS_SYNC_DEPTH = 3;
  localparam int          OSS_P_SLD      = 0;
  localparam int          OSS_P_CLR      = 1;
  localparam int          OSS_P_CS       = 2;
  localparam int          OSS_P_OT       = 3;
  localparam int          OSS_P_SH       = 11;
  localparam int          OSS_P_DR       = 19;
  localparam int          OSS_PIN_W      = 27;
  // deselected, clear asserted, all drains high
  localparam logic [26:0] OSS_PIN_RST    = 27'h7F80004;

  typedef enum logic [1:0] {
    OSS_FR_IDLE,
    OSS_FR_ACTIVE,
    OSS_FR_VOID
  } oss_frame_e;

endpackage : oss_pkg

// >>> oss_link_if.sv
// words passed between the system-clock side and the serial-clock side
interface oss_link_if;
  logic [7:0] status;
  logic [7:0] rx;

  modport sys (
    output status,
    input  rx
  );

  modport link (
    input  status,
    output rx
  );
endinterface : oss_link_if

// >>> oss_link.sv
// serial-clock side: input shift register, status readout, output driver enable
module oss_link
  import oss_pkg::*;
(
  input  wire logic  sclk,
  input  wire logic  cs_n,
  input  wire logic  resetn,
  input  wire logic  si,
  output logic       so,
  output logic       so_oe,
  oss_link_if.link   lk
);

  logic [OSS_CNT_W-1:0] fcnt_r;
  logic [7:0]           rx_r;
  logic                 so_r;
  logic                 rose_r;

  //////////////////////////////////////////////////////////////////////////////
  // counters clear while deselected; sclk may stand still, so cs_n does it
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fcnt_r <= OSS_CNT_RST;
    end else if (fcnt_r != OSS_FULL) begin
      fcnt_r <= fcnt_r + 4'h1;
    end
  end

  // received bits survive deselection so the system side can latch them
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      rx_r <= OSS_WORD_RST;
    end else if (!cs_n) begin
      rx_r <= {rx_r[6:0], si};
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_r   <= 1'b0;
      rose_r <= 1'b0;
    end else begin
      rose_r <= 1'b1;
      if (fcnt_r == OSS_FULL) begin
        so_r <= rx_r[7];
      end else begin
        so_r <= lk.status[3'(OSS_MSB - fcnt_r[2:0])];
      end
    end
  end

  // msb of the frozen status word is on the pin before any clock edge
  assign so    = rose_r ? so_r : lk.status[OSS_MSB];
  assign so_oe = !cs_n;
  assign lk.rx = rx_r;

  //////////////////////////////////////////////////////////////////////////////
  a_pass_through: assert property (
    @(posedge sclk) disable iff (cs_n)
    (fcnt_r == OSS_FULL) |=> (so_r == $past(rx_r[7])))
    else $error("bit did not pass through after eight clocks");

  a_sample_in: assert property (
    @(negedge sclk) disable iff (cs_n || !resetn)
    1'b1 |=> (rx_r[0] == $past(si)))
    else $error("serial input not sampled on falling clock");

endmodule : oss_link

// >>> oss_top.sv
// top of the octal switch serial control block, system-clock side
module oss_top
  import oss_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               si,
  output logic                    so,
  output logic                    so_oe,
  input  wire logic               clear_n,
  input  wire logic               short_latch_disable,
  input  wire logic [OSS_CH-1:0]  drain_hi,
  input  wire logic [OSS_CH-1:0]  short_det,
  input  wire logic [OSS_CH-1:0]  over_temp,
  output logic      [OSS_CH-1:0]  sw_on,
  output logic      [OSS_CH-1:0]  cur_limit,
  output logic      [OSS_CH-1:0]  fault_latched,
  output logic      [OSS_CH-1:0]  cmd_word,
  output logic                    selected,
  output logic                    frame_done
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  oss_link_if lk ();

  logic [OSS_PIN_W-1:0] pin_s1_r;
  logic [OSS_PIN_W-1:0] pin_s2_r;
  logic [OSS_PIN_W-1:0] pin_s3_r;
  logic [OSS_PIN_W-1:0] pin_lvl_r;
  logic [OSS_PIN_W-1:0] pin_vec;

  logic                 cs_lvl;
  logic                 cs_prev_r;
  logic                 cs_rise;
  logic                 cs_fall;
  logic                 clear_act;
  logic                 sld;
  logic [OSS_CH-1:0]    drain_s;
  logic [OSS_CH-1:0]    short_s;
  logic [OSS_CH-1:0]    ot_s;

  oss_frame_e           state_r;
  oss_frame_e           state_nxt;
  logic                 do_latch;

  logic [OSS_CH-1:0]    cmd_r;
  logic [OSS_CH-1:0]    status_r;
  logic [OSS_CH-1:0]    latched_r;
  logic [OSS_CH-1:0]    latched_nxt;
  logic [OSS_CH-1:0]    sw_on_r;
  logic [OSS_CH-1:0]    sw_on_nxt;
  logic [OSS_CH-1:0]    cur_lim_r;
  logic                 selected_r;
  logic                 frame_done_r;

  // a bit takes a new level only once the second and third stages agree
  function automatic logic [OSS_PIN_W-1:0] agree_upd(
    input logic [OSS_PIN_W-1:0] lvl,
    input logic [OSS_PIN_W-1:0] s2,
    input logic [OSS_PIN_W-1:0] s3
  );
    logic [OSS_PIN_W-1:0] same;
    same      = ~(s2 ^ s3);
    agree_upd = (same & s2) | (~same & lvl);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // serial-clock side

  oss_link u_link (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .resetn (resetn),
    .si     (si),
    .so     (so),
    .so_oe  (so_oe),
    .lk     (lk.link)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only

  assign pin_vec = {drain_hi, short_det, over_temp, cs_n, clear_n, short_latch_disable};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= OSS_PIN_RST;
      pin_s2_r <= OSS_PIN_RST;
      pin_s3_r <= OSS_PIN_RST;
    end else begin
      pin_s1_r <= pin_vec;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_lvl_r <= OSS_PIN_RST;
    end else begin
      pin_lvl_r <= agree_upd(pin_lvl_r, pin_s2_r, pin_s3_r);
    end
  end

  assign cs_lvl    = pin_lvl_r[OSS_P_CS];
  assign clear_act = !pin_lvl_r[OSS_P_CLR];
  assign sld       = pin_lvl_r[OSS_P_SLD];
  assign drain_s   = pin_lvl_r[OSS_P_DR +: OSS_CH];
  assign short_s   = pin_lvl_r[OSS_P_SH +: OSS_CH];
  assign ot_s      = pin_lvl_r[OSS_P_OT +: OSS_CH];

  //////////////////////////////////////////////////////////////////////////////
  // select edges and frame tracking

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cs_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_lvl;
    end
  end

  assign cs_rise = cs_lvl && !cs_prev_r;
  assign cs_fall = !cs_lvl && cs_prev_r;

  // a frame touched by clear is void: its bits are thrown away at release
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OSS_FR_IDLE: begin
        if (cs_fall && !clear_act) begin
          state_nxt = OSS_FR_ACTIVE;
        end else if (cs_fall) begin
          state_nxt = OSS_FR_VOID;
        end
      end
      OSS_FR_ACTIVE: begin
        if (clear_act) begin
          state_nxt = OSS_FR_VOID;
        end else if (cs_rise) begin
          state_nxt = OSS_FR_IDLE;
        end
      end
      OSS_FR_VOID: begin
        if (cs_rise) begin
          state_nxt = OSS_FR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= OSS_FR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign do_latch = cs_rise && (state_r == OSS_FR_ACTIVE) && !clear_act;

  //////////////////////////////////////////////////////////////////////////////
  // command latch; the shift word is still since rx_r only shifts while cs_n is low

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_r <= OSS_ALL_OFF;
    end else if (clear_act) begin
      cmd_r <= OSS_ALL_OFF;
    end else if (do_latch) begin
      cmd_r <= lk.rx;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status capture; frozen while selected so the serial side reads a
  // stable word. the snapshot is the last drain level seen before the
  // synchronised select fell, as sampled at the clock that first caught the select pin low.

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= OSS_ALL_OFF;
    end else if (cs_lvl) begin
      status_r <= drain_s;
    end
  end

  assign lk.status = status_r;

  //////////////////////////////////////////////////////////////////////////////
  // output channels

  generate
    for (genvar i = 0; i < OSS_CH; i++) begin : g_ch
      // a fresh command re-arms a latched channel
      always_comb begin
        latched_nxt[i] = latched_r[i];
        if (clear_act || do_latch) begin
          latched_nxt[i] = 1'b0;
        end
        if (!sld && short_s[i] && sw_on_r[i]) begin
          latched_nxt[i] = 1'b1;
        end
        sw_on_nxt[i] = !cmd_r[i] && !latched_nxt[i] && !ot_s[i] && !clear_act;
      end

      a_short_latch: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (!sld && short_s[i] && sw_on_r[i]) |=> (!sw_on_r[i] && latched_r[i]))
        else $error("shorted channel not latched off");

      a_limit_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (sld && short_s[i] && !cmd_r[i] && !ot_s[i] && !clear_act && !latched_r[i]
          && !do_latch) |=> (sw_on_r[i] && cur_lim_r[i]))
        else $error("shorted channel left current limit mode");
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      latched_r <= OSS_ALL_ON;
    end else begin
      latched_r <= latched_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sw_on_r   <= OSS_ALL_ON;
      cur_lim_r <= OSS_ALL_ON;
    end else begin
      sw_on_r   <= sw_on_nxt;
      cur_lim_r <= sw_on_nxt & short_s & {OSS_CH{sld}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status outputs

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      selected_r   <= 1'b0;
      frame_done_r <= 1'b0;
    end else begin
      selected_r   <= !cs_lvl;
      frame_done_r <= do_latch;
    end
  end

  assign sw_on         = sw_on_r;
  assign cur_limit     = cur_lim_r;
  assign fault_latched = latched_r;
  assign cmd_word      = cmd_r;
  assign selected      = selected_r;
  assign frame_done    = frame_done_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_latch_on_rise: assert property (
    do_latch |=> (cmd_r == $past(lk.rx))
      ##1 ($past(clear_act) || cmd_word == $past(lk.rx, 2)))
    else $error("command not latched at select release");

  a_frame_pulse: assert property (
    do_latch |=> frame_done ##1 !frame_done)
    else $error("frame done not a single pulse");

  a_status_freeze: assert property (
    !cs_lvl ##1 !cs_lvl |-> $stable(status_r))
    else $error("status word moved while selected");

  a_cmd_polarity: assert property (
    !clear_act |=> ((sw_on_r & $past(cmd_r)) == OSS_ALL_ON))
    else $error("channel on although commanded off");

  a_clear_off: assert property (
    clear_act |=> (cmd_r == OSS_ALL_OFF) && (sw_on_r == OSS_ALL_ON))
    else $error("clear did not turn outputs off");

  a_void_frame: assert property (
    (state_r == OSS_FR_VOID && cs_rise) |=> (cmd_r == OSS_ALL_OFF || $stable(cmd_r)))
    else $error("cleared frame was latched");

  // checks on whole words and the selected flag; one thread per check keeps the run light
  a_status_load: assert property (
    cs_lvl |=> (status_r == $past(drain_s)))
    else $error("status word not taken while deselected");

  a_select_state: assert property (
    1'b1 |=> (selected == !$past(cs_lvl)))
    else $error("selected flag does not follow select");

  a_thermal_off: assert property (
    1'b1 |=> ((sw_on_r & $past(ot_s)) == OSS_ALL_ON))
    else $error("hot channel left on");

  a_no_limit_latch: assert property (
    !sld |=> (cur_lim_r == OSS_ALL_ON))
    else $error("current limit flagged in latch-off mode");

  a_latch_hold: assert property (
    (!clear_act && !do_latch) |=> ((latched_r & $past(latched_r)) == $past(latched_r)))
    else $error("latched channel released without command or clear");

  c_frame: cover property (cs_fall ##[1:300] do_latch);
  c_clear_mid: cover property (state_r == OSS_FR_ACTIVE ##1 state_r == OSS_FR_VOID);
  c_latch_off: cover property (!sld && short_s != OSS_ALL_ON && sw_on_r != OSS_ALL_ON);
  c_limit: cover property (cur_lim_r != OSS_ALL_ON);
  c_void_rise: cover property (state_r == OSS_FR_VOID && cs_rise);

endmodule : oss_top

// >>> oss_master.sv
// serial master model standing on the far side of the select, clock and data pins
module oss_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_line
);
  timeunit 1ns;
  timeprecision 100ps;

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    si   = 1'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sends n bits of d msb first, samples the reply where the device holds it
  task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] q);
    q = 16'h0000;
    sclk = 1'h0;
    cs_n = 1'h0;
    // select settles through the device synchroniser before the first edge
    #250;
    for (int i = n - 1; i >= 0; i--) begin
      // data moves a moment after the falling edge, never in its time step
      #1 si = d[i];
      #2 sclk = 1'h1;
      #3 q[i] = so_line;
      sclk = 1'h0;
    end
    #3 cs_n = 1'h1;
    // a released line must not keep looking valid
    si = ~si;
  endtask

  // clock and data wiggled while deselected, a deliberate misuse
  task automatic noise();
    for (int i = 0; i < 5; i++) begin
      si = ~si;
      #3 sclk = 1'h1;
      #3 sclk = 1'h0;
    end
  endtask
endmodule // oss_master

// >>> oss_top_tb_top.sv
// self-checking bench for the octal switch serial control block
module oss_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import oss_pkg::*;

  logic        sys_clk;
  logic        resetn;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  wire         so_line;
  logic        clear_n;
  logic        short_latch_disable;
  logic [7:0]  drain_hi;
  logic [7:0]  short_det;
  logic [7:0]  over_temp;
  logic [7:0]  sw_on;
  logic [7:0]  cur_limit;
  logic [7:0]  fault_latched;
  logic [7:0]  cmd_word;
  logic        selected;
  logic        frame_done;
  logic [15:0] st;
  int          fails;
  int          num_checks;

  //////////////////////////////////////////////////////////////////////////////
  assign so_line = so_oe ? so : 1'hz;

  oss_top dut (
    .sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .clear_n(clear_n),
    .short_latch_disable(short_latch_disable), .drain_hi(drain_hi),
    .short_det(short_det), .over_temp(over_temp), .sw_on(sw_on),
    .cur_limit(cur_limit), .fault_latched(fault_latched), .cmd_word(cmd_word),
    .selected(selected), .frame_done(frame_done)
  );

  oss_master m (.sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line));

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // drains settle well before the next select so the snapshot sees them
  task automatic load(input logic [7:0] v);
    drain_hi = v;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic frame(input logic [15:0] d, input int n, output logic [15:0] q);
    int k;
    m.xfer(d, n, q);
    k = 0;
    while (frame_done !== 1'h1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    if (frame_done !== 1'h1) begin
      fails++;
      $display("[FAIL] %0t frame done never seen", $time);
      summarize();
    end
    repeat (3) @(negedge sys_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    num_checks = 0;
    resetn = 1'h0;
    clear_n = 1'h0;
    short_latch_disable = 1'h0;
    drain_hi = 8'hFF;
    short_det = 8'h00;
    over_temp = 8'h00;
    repeat (16) @(negedge sys_clk);
    resetn = 1'h1;
    clear_n = 1'h1;
    repeat (8) @(negedge sys_clk);
    chk(cmd_word, 8'hFF, "reset command");
    chk(sw_on, 8'h00, "reset outputs");
    chk({7'h00, so_oe}, 8'h00, "idle output floats");
    frame(16'h00A5, 8, st);
    chk(st[7:0], 8'hFF, "status of off drains");
    chk(cmd_word, 8'hA5, "latched command");
    chk(sw_on, 8'h5A, "zero bits switch on");
    // output 4 drain disagrees with its command, as a fault would
    load(8'hB5);
    frame(16'h00C3, 8, st);
    chk(st[7:0], 8'hB5, "status msb first");
    load(8'hC3);
    m.noise();
    repeat (10) @(negedge sys_clk);
    chk(cmd_word, 8'hC3, "clock ignored when idle");
    frame(16'h3C96, 16, st);
    chk(st[15:8], 8'hC3, "status before pass");
    chk(st[7:0], 8'h3C, "pass through late bits");
    chk(cmd_word, 8'h96, "last eight kept");
    load(8'h5A);
    clear_n = 1'h0;
    fork
      m.xfer(16'h0000, 8, st);
      begin
        repeat (5) @(negedge sys_clk);
        chk({7'h00, selected}, 8'h01, "selected during frame");
        chk({7'h00, so_oe}, 8'h01, "output driven when selected");
      end
    join
    repeat (10) @(negedge sys_clk);
    chk({7'h00, selected}, 8'h00, "deselected after frame");
    chk(st[7:0], 8'h5A, "status under clear");
    chk(cmd_word, 8'hFF, "clear forces off");
    chk(sw_on, 8'h00, "all outputs off");
    clear_n = 1'h1;
    repeat (8) @(negedge sys_clk);
    chk(cmd_word, 8'hFF, "void frame under clear");
    load(8'hFF);
    frame(16'h0000, 8, st);
    chk(sw_on, 8'hFF, "all on");
    short_det = 8'h04;
    repeat (6) @(negedge sys_clk);
    short_det = 8'h00;
    repeat (6) @(negedge sys_clk);
    chk(sw_on, 8'hFB, "short latches one off");
    chk(fault_latched, 8'h04, "latch flag");
    short_latch_disable = 1'h1;
    load(8'h00);
    frame(16'h0000, 8, st);
    chk(fault_latched, 8'h00, "re-armed by command");
    short_det = 8'h20;
    repeat (6) @(negedge sys_clk);
    chk(sw_on, 8'hFF, "limit keeps on");
    chk(cur_limit, 8'h20, "limit flag");
    over_temp = 8'h20;
    repeat (6) @(negedge sys_clk);
    chk(sw_on, 8'hDF, "thermal stop");
    summarize();
  end
endmodule // oss_top_tb_top
